/* logic/lbc_pkg.sv */
// shared constants and types of the local bus controller
package lbc_pkg;
    localparam int unsigned LBC_NUM_MODULES = 4;  // local ports, the controller itself excluded
    localparam int unsigned LBC_LEAF_W      = 2;
    localparam int unsigned LBC_MID_W       = 4;
    localparam int unsigned LBC_LADDR_W     = 12;
    localparam int unsigned LBC_DATA_W      = 8;

    // external address layout: module id on top, local address just below
    localparam int unsigned LBC_MID_MSB     = 31;
    localparam int unsigned LBC_MID_LSB     = 28;
    localparam int unsigned LBC_LADDR_MSB   = 27;
    localparam int unsigned LBC_LADDR_LSB   = 16;

    // local address: register part above, byte select below
    localparam int unsigned LBC_REG_MSB     = 11;
    localparam int unsigned LBC_REG_LSB     = 4;
    localparam int unsigned LBC_BSEL_MSB    = 3;
    localparam int unsigned LBC_BSEL_LSB    = 0;

    // module id that addresses the controller itself
    localparam logic [3:0] LBC_MID_SELF     = 4'he;
    // module ids of the local ports, port index i in nibble i
    localparam logic [15:0] LBC_LEAF_MIDS   = 16'h9821;

    // register part of the local address for the controller's own functions
    localparam logic [7:0] LBC_REG_RECONFIG = 8'h00;
    localparam logic [7:0] LBC_REG_SOFT_RST = 8'h01;
    localparam logic [7:0] LBC_REG_VERSION  = 8'h02;

    // version word; arbitrary value
    localparam logic [31:0] LBC_FW_VERSION  = 32'h0001_0000;
    localparam logic [3:0] LBC_VER_BYTES    = 4'h4;

    // soft reset pulse: time in ns and the cycle count at 100 MHz
    localparam int unsigned LBC_CLK_NS      = 10;
    localparam int unsigned LBC_RST_NS      = 80;
    localparam logic [3:0] LBC_RST_CYC      = 4'((LBC_RST_NS + LBC_CLK_NS - 1) / LBC_CLK_NS);

    typedef enum logic [2:0] {
        LBC_IDLE    = 3'h0,
        LBC_DEST    = 3'h1,   // dest_decode_state
        LBC_BCAST   = 3'h3,   // bus_broadcast_state
        LBC_CONNECT = 3'h2,
        LBC_WAIT    = 3'h6,
        LBC_TERM    = 3'h7,
        LBC_ACK     = 3'h5
    } lbc_state_t;
endpackage

/* logic/lbc_leaf_if.sv */
// one local bus port between port gate and the local module on the lb_* pins
`timescale 1ns/1ps
interface lbc_leaf_if;
    logic       we;
    logic       re;
    logic       ready;
    logic [7:0] rdata;
    modport ctrl (output we, output re, input ready, input rdata);
    modport leaf (input we, input re, output ready, output rdata);
endinterface

/* logic/lbc_dest_decode.sv */
// module id to controller hit or local port index
`timescale 1ns/1ps
module lbc_dest_decode (
    // module id
    input  wire logic [3:0] mid,
    // decision
    output logic            hit_self,
    output logic            hit_leaf,
    output logic [1:0]      leaf_idx
);
    always_comb begin
        hit_self = (mid == lbc_pkg::LBC_MID_SELF);
        hit_leaf = 1'b0;
        leaf_idx = 2'h0;
        // ids may be scattered, indices stay contiguous
        for (int i = 0; i < lbc_pkg::LBC_NUM_MODULES; i++) begin
            if (!hit_self && mid == lbc_pkg::LBC_LEAF_MIDS[i*lbc_pkg::LBC_MID_W +: lbc_pkg::LBC_MID_W]) begin
                hit_leaf = 1'b1;
                leaf_idx = 2'(i);
            end
        end
    end
endmodule

/* logic/lbc_leaf_port.sv */
// strobe gate and response gate for one local port
`timescale 1ns/1ps
module lbc_leaf_port #(
    parameter logic [1:0] IDX = 2'h0
) (
    // from controller core
    input  wire logic [1:0] leaf_sel,
    input  wire logic       we_on,
    input  wire logic       re_on,
    // gated response
    output logic            sel_ready,
    output logic [7:0]      sel_rdata,
    // port
    lbc_leaf_if.ctrl        port
);
    logic hit;
    assign hit        = (leaf_sel == IDX);
    assign port.we    = hit & we_on;
    assign port.re    = hit & re_on;
    assign sel_ready  = hit & port.ready;
    // a stray ready from an unselected port never reaches the core
    assign sel_rdata  = (hit & port.ready) ? port.rdata : 8'h00;
endmodule

/* logic/lbc_local_bus_controller.sv */
// local bus controller: external register strobes to byte-wide local ports
// Overview of operation
// - a transaction starts when external write or read strobe is high
// - address and data are captured at the start and rearranged for the local bus
// - a decode state looks at the module id to choose self or a port
// - self-addressed: reconfiguration request, soft reset, or version read
// - port index for a local module comes from the module id
// - local address and write data are broadcast to all ports
// - only the selected port sees its write or read strobe
// - controller waits after strobing until the selected port answers ready
// - on ready, termination step, then acknowledge to the external master
// - each local transfer moves one byte; wide registers need several
// - local address is 12 bits, register above, byte select in low 4
// - module id is external address top nibble, local address the 12 below
// - reconfiguration request output idles high; low reloads the device
// - module count excludes the controller; port indices are contiguous
`timescale 1ns/1ps
module lbc_local_bus_controller (
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     nrst,
    // external register bus
    input  wire logic [31:0]              ext_addr,
    input  wire logic [7:0]               ext_wdata,
    input  wire logic                     ext_we,
    input  wire logic                     read_strobe,
    output logic                          ext_ack,
    output logic [7:0]                    ext_rdata,
    // local bus, shared part
    output logic [11:0]                   lb_addr,
    output logic [7:0]                    lb_wdata,
    // local bus, one bit or byte per port
    output logic [3:0]                    lb_we,
    output logic [3:0]                    lb_re,
    input  wire logic [3:0]               lb_ready,
    input  wire logic [3:0][7:0]          lb_rdata,
    // device control
    output logic                          fpga_reconfig_n,
    output logic                          soft_rst
);
    typedef struct packed {
        lbc_pkg::lbc_state_t st;
        logic [3:0]          mid;
        logic [11:0]         laddr;
        logic [7:0]          wdata;
        logic                wr;
        logic [1:0]          leaf;
        logic                we_on;
        logic                re_on;
        logic [7:0]          rdata;
        logic                ack;
        logic                reconf_n;
        logic [3:0]          rst_cnt;
    } lbc_ctl_state_t;

    localparam lbc_ctl_state_t CTL_RESET = '{
        st:       lbc_pkg::LBC_IDLE,
        mid:      4'h0,
        laddr:    12'h000,
        wdata:    8'h00,
        wr:       1'b0,
        leaf:     2'h0,
        we_on:    1'b0,
        re_on:    1'b0,
        rdata:    8'h00,
        ack:      1'b0,
        reconf_n: 1'b1,
        rst_cnt:  4'h0
    };

    lbc_ctl_state_t ctl_reg;
    lbc_ctl_state_t ctl_next;

    logic           hit_self;
    logic           hit_leaf;
    logic [1:0]     leaf_idx;
    logic [3:0]     port_ready;
    logic [3:0][7:0] port_rdata;
    logic           sel_ready;
    logic [7:0]     sel_rdata;
    logic [7:0]     own_reg;
    logic [3:0]     own_bsel;

    lbc_dest_decode u_dest (
        .mid      (ctl_reg.mid),
        .hit_self (hit_self),
        .hit_leaf (hit_leaf),
        .leaf_idx (leaf_idx)
    );

    lbc_leaf_if lif [lbc_pkg::LBC_NUM_MODULES] ();

    generate
        for (genvar g = 0; g < lbc_pkg::LBC_NUM_MODULES; g++) begin : g_port
            lbc_leaf_port #(.IDX(2'(g))) u_port (
                .leaf_sel  (ctl_reg.leaf),
                .we_on     (ctl_reg.we_on),
                .re_on     (ctl_reg.re_on),
                .sel_ready (port_ready[g]),
                .sel_rdata (port_rdata[g]),
                .port      (lif[g])
            );
            assign lb_we[g]        = lif[g].we;
            assign lb_re[g]        = lif[g].re;
            assign lif[g].ready    = lb_ready[g];
            assign lif[g].rdata    = lb_rdata[g];
        end
    endgenerate

    // only the selected port can be non-zero, so or-ing is a mux
    always_comb begin
        sel_ready = |port_ready;
        sel_rdata = 8'h00;
        for (int i = 0; i < lbc_pkg::LBC_NUM_MODULES; i++) begin
            sel_rdata = sel_rdata | port_rdata[i];
        end
    end

    assign own_reg  = ctl_reg.laddr[lbc_pkg::LBC_REG_MSB:lbc_pkg::LBC_REG_LSB];
    assign own_bsel = ctl_reg.laddr[lbc_pkg::LBC_BSEL_MSB:lbc_pkg::LBC_BSEL_LSB];

    always_comb begin
        ctl_next = ctl_reg;
        if (ctl_reg.rst_cnt != 4'h0) begin
            ctl_next.rst_cnt = ctl_reg.rst_cnt - 4'h1;
        end
        unique case (ctl_reg.st)
            lbc_pkg::LBC_IDLE: begin
                ctl_next.ack = 1'b0;
                if (ext_we || read_strobe) begin
                    ctl_next.mid   = ext_addr[lbc_pkg::LBC_MID_MSB:lbc_pkg::LBC_MID_LSB];
                    ctl_next.laddr = ext_addr[lbc_pkg::LBC_LADDR_MSB:lbc_pkg::LBC_LADDR_LSB];
                    ctl_next.wdata = ext_wdata;
                    ctl_next.wr    = ext_we;
                    ctl_next.st    = lbc_pkg::LBC_DEST;
                end
            end
            lbc_pkg::LBC_DEST: begin
                ctl_next.rdata = 8'h00;
                if (hit_self) begin
                    if (ctl_reg.wr && own_reg == lbc_pkg::LBC_REG_RECONFIG) begin
                        ctl_next.reconf_n = 1'b0;
                    end
                    if (ctl_reg.wr && own_reg == lbc_pkg::LBC_REG_SOFT_RST) begin
                        ctl_next.rst_cnt = lbc_pkg::LBC_RST_CYC;
                    end
                    if (!ctl_reg.wr && own_reg == lbc_pkg::LBC_REG_VERSION && own_bsel < lbc_pkg::LBC_VER_BYTES) begin
                        ctl_next.rdata = lbc_pkg::LBC_FW_VERSION[own_bsel[1:0]*8 +: 8];
                    end
                    ctl_next.st = lbc_pkg::LBC_TERM;
                end else if (hit_leaf) begin
                    ctl_next.leaf = leaf_idx;
                    ctl_next.st   = lbc_pkg::LBC_BCAST;
                end else begin
                    // unknown id: answered with zero rather than hanging the master
                    ctl_next.st = lbc_pkg::LBC_TERM;
                end
            end
            lbc_pkg::LBC_BCAST: begin
                // address and data already sit on the shared bus
                ctl_next.st = lbc_pkg::LBC_CONNECT;
            end
            lbc_pkg::LBC_CONNECT: begin
                ctl_next.we_on = ctl_reg.wr;
                ctl_next.re_on = !ctl_reg.wr;
                ctl_next.st    = lbc_pkg::LBC_WAIT;
            end
            lbc_pkg::LBC_WAIT: begin
                if (sel_ready) begin
                    ctl_next.rdata = ctl_reg.wr ? 8'h00 : sel_rdata;
                    ctl_next.st    = lbc_pkg::LBC_TERM;
                end
            end
            lbc_pkg::LBC_TERM: begin
                ctl_next.ack = 1'b1;
                ctl_next.st  = lbc_pkg::LBC_ACK;
            end
            lbc_pkg::LBC_ACK: begin
                ctl_next.ack   = 1'b0;
                ctl_next.we_on = 1'b0;
                ctl_next.re_on = 1'b0;
                ctl_next.st    = lbc_pkg::LBC_IDLE;
            end
            default: begin
                ctl_next = CTL_RESET;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctl_reg <= CTL_RESET;
        end else begin
            ctl_reg <= ctl_next;
        end
    end

    assign ext_ack         = ctl_reg.ack;
    assign ext_rdata       = ctl_reg.rdata;
    assign lb_addr         = ctl_reg.laddr;
    assign lb_wdata        = ctl_reg.wdata;
    assign fpga_reconfig_n = ctl_reg.reconf_n;
    assign soft_rst        = (ctl_reg.rst_cnt != 4'h0);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_start;
        ctl_reg.st == lbc_pkg::LBC_IDLE && (ext_we || read_strobe) |=> ctl_reg.st == lbc_pkg::LBC_DEST;
    endproperty
    a_start: assert property (p_start) else $error("strobe did not start a transaction");

    property p_capture;
        ctl_reg.st == lbc_pkg::LBC_IDLE && (ext_we || read_strobe)
            |=> lb_addr == $past(ext_addr[lbc_pkg::LBC_LADDR_MSB:lbc_pkg::LBC_LADDR_LSB])
            && lb_wdata == $past(ext_wdata);
    endproperty
    a_capture: assert property (p_capture) else $error("address or data not captured");

    property p_mid;
        ctl_reg.st == lbc_pkg::LBC_IDLE && (ext_we || read_strobe)
            |=> ctl_reg.mid == $past(ext_addr[lbc_pkg::LBC_MID_MSB:lbc_pkg::LBC_MID_LSB]);
    endproperty
    a_mid: assert property (p_mid) else $error("module id taken from wrong bits");

    property p_one_port;
        $onehot0(lb_we | lb_re) && !(|(lb_we & lb_re));
    endproperty
    a_one_port: assert property (p_one_port) else $error("more than one port strobed");

    property p_connect;
        ctl_reg.st == lbc_pkg::LBC_CONNECT
            |=> (ctl_reg.wr ? lb_we[ctl_reg.leaf] : lb_re[ctl_reg.leaf]) && $stable(lb_addr);
    endproperty
    a_connect: assert property (p_connect) else $error("selected port not strobed");

    property p_wait;
        ctl_reg.st == lbc_pkg::LBC_WAIT && !sel_ready |=> ctl_reg.st == lbc_pkg::LBC_WAIT && !ext_ack;
    endproperty
    a_wait: assert property (p_wait) else $error("left wait without ready");

    property p_ack;
        ctl_reg.st == lbc_pkg::LBC_WAIT && sel_ready |=> !ext_ack ##1 ext_ack ##1 !ext_ack;
    endproperty
    a_ack: assert property (p_ack) else $error("acknowledge not two cycles after ready");

    property p_idle;
        ext_ack |=> ctl_reg.st == lbc_pkg::LBC_IDLE && lb_we == 4'h0 && lb_re == 4'h0;
    endproperty
    a_idle: assert property (p_idle) else $error("strobes not released after acknowledge");

    property p_rdata;
        ctl_reg.st == lbc_pkg::LBC_WAIT && sel_ready && !ctl_reg.wr
            |=> ##1 ext_ack && ext_rdata == $past(sel_rdata, 2);
    endproperty
    a_rdata: assert property (p_rdata) else $error("read byte not returned with acknowledge");

    property p_reconfig;
        $fell(fpga_reconfig_n) |-> $past(ctl_reg.st) == lbc_pkg::LBC_DEST && $past(hit_self) && $past(ctl_reg.wr);
    endproperty
    a_reconfig: assert property (p_reconfig) else $error("reconfiguration request without a write");

    property p_bus_stable;
        ctl_reg.st != lbc_pkg::LBC_IDLE |=> $stable(lb_addr) && $stable(lb_wdata);
    endproperty
    a_bus_stable: assert property (p_bus_stable) else $error("shared bus changed mid transaction");

    property p_strobe_state;
        (lb_we | lb_re) != 4'h0 |-> ctl_reg.st inside {lbc_pkg::LBC_WAIT, lbc_pkg::LBC_TERM, lbc_pkg::LBC_ACK};
    endproperty
    a_strobe_state: assert property (p_strobe_state) else $error("port strobed outside wait");

    property p_self;
        ctl_reg.st == lbc_pkg::LBC_DEST && hit_self
            |=> ctl_reg.st == lbc_pkg::LBC_TERM ##1 ext_ack && lb_we == 4'h0 && lb_re == 4'h0;
    endproperty
    a_self: assert property (p_self) else $error("self access not acknowledged cleanly");

    // the highest id must land on the last index: ids scattered, indices contiguous
    property p_last_port;
        ctl_reg.st == lbc_pkg::LBC_DEST && ctl_reg.mid == lbc_pkg::LBC_LEAF_MIDS[15:12]
            |=> ctl_reg.st == lbc_pkg::LBC_BCAST && ctl_reg.leaf == 2'h3;
    endproperty
    a_last_port: assert property (p_last_port) else $error("top id not on last port");

    property p_soft_rst;
        ctl_reg.st == lbc_pkg::LBC_DEST && hit_self && ctl_reg.wr && own_reg == lbc_pkg::LBC_REG_SOFT_RST
            |=> soft_rst [*8];
    endproperty
    a_soft_rst: assert property (p_soft_rst) else $error("soft reset pulse too short");

    property p_version;
        ctl_reg.st == lbc_pkg::LBC_DEST && hit_self && !ctl_reg.wr && own_reg == lbc_pkg::LBC_REG_VERSION
            && own_bsel == 4'h2 |=> ext_rdata == lbc_pkg::LBC_FW_VERSION[23:16];
    endproperty
    a_version: assert property (p_version) else $error("wrong version byte returned");

    property p_reconf_hold;
        fpga_reconfig_n && !(ctl_reg.st == lbc_pkg::LBC_DEST && hit_self && ctl_reg.wr) |=> fpga_reconfig_n;
    endproperty
    a_reconf_hold: assert property (p_reconf_hold) else $error("reconfiguration request dropped");
endmodule

/* verif/lbc_leaf_model.sv */
// behavioural local modules on the four ports: byte store with settable answer delay
`timescale 1ns/1ps
module lbc_leaf_model (
    // clock and reset
    input  wire logic            clk,
    input  wire logic            nrst,
    // shared bus
    input  wire logic [11:0]     lb_addr,
    input  wire logic [7:0]      lb_wdata,
    // per port
    input  wire logic [3:0]      lb_we,
    input  wire logic [3:0]      lb_re,
    output logic      [3:0]      lb_ready,
    output logic      [3:0][7:0] lb_rdata,
    // scenario control
    input  wire logic [3:0][3:0] delay,
    input  wire logic            noise
);
    logic [7:0]      mem [0:16383];
    logic [3:0][3:0] cnt;
    logic [3:0]      done;
    logic [3:0]      rdy;
    logic [3:0][7:0] last;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt  <= '0;
            done <= '0;
            rdy  <= '0;
            last <= '0;
        end else begin
            for (int p = 0; p < 4; p++) begin
                rdy[p] <= 1'b0;
                if (!(lb_we[p] || lb_re[p])) begin
                    cnt[p]  <= 4'h0;
                    done[p] <= 1'b0;
                end else if (!done[p] && cnt[p] == delay[p]) begin
                    rdy[p]  <= 1'b1;
                    done[p] <= 1'b1;
                    if (lb_we[p]) begin
                        mem[{p[1:0], lb_addr}] <= lb_wdata;
                    end else begin
                        last[p] <= mem[{p[1:0], lb_addr}];
                    end
                end else if (!done[p]) begin
                    cnt[p] <= cnt[p] + 4'h1;
                end
            end
        end
    end

    // released data shows the inverse so a stale byte never passes for a match
    always_comb begin
        for (int p = 0; p < 4; p++) begin
            lb_ready[p] = rdy[p] | (noise & ~(lb_we[p] | lb_re[p]));
            lb_rdata[p] = rdy[p] ? last[p] : ~last[p];
        end
    end
endmodule

/* verif/tb_local_bus_controller.sv */
// self-checking bench of the local bus controller
`timescale 1ns/1ps
module tb_local_bus_controller;
    logic            clk;
    logic            nrst;
    logic [31:0]     ext_addr;
    logic [7:0]      ext_wdata;
    logic            ext_we;
    logic            read_strobe;
    logic            ext_ack;
    logic [7:0]      ext_rdata;
    logic [11:0]     lb_addr;
    logic [7:0]      lb_wdata;
    logic [3:0]      lb_we;
    logic [3:0]      lb_re;
    logic [3:0]      lb_ready;
    logic [3:0][7:0] lb_rdata;
    logic            fpga_reconfig_n;
    logic            soft_rst;
    logic [3:0][3:0] delay;
    logic            noise;
    logic [3:0]      seen_we;
    logic [3:0]      seen_re;
    logic [11:0]     seen_addr;
    logic [7:0]      seen_wdata;
    logic            both;
    int              n_mismatch;
    int              check_count;
    int              cycles;
    int              lat;
    int              rst_len;

    lbc_local_bus_controller i_dut (.clk(clk), .nrst(nrst), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
        .ext_we(ext_we), .read_strobe(read_strobe), .ext_ack(ext_ack), .ext_rdata(ext_rdata),
        .lb_addr(lb_addr), .lb_wdata(lb_wdata), .lb_we(lb_we), .lb_re(lb_re), .lb_ready(lb_ready),
        .lb_rdata(lb_rdata), .fpga_reconfig_n(fpga_reconfig_n), .soft_rst(soft_rst));

    lbc_leaf_model i_leaves (.clk(clk), .nrst(nrst), .lb_addr(lb_addr), .lb_wdata(lb_wdata), .lb_we(lb_we),
        .lb_re(lb_re), .lb_ready(lb_ready), .lb_rdata(lb_rdata), .delay(delay), .noise(noise));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // hang guard: the whole run needs well under 20000 cycles
    always @(posedge clk) begin
        cycles++;
        if (soft_rst === 1'b1) begin
            rst_len++;
        end
        if (cycles == 20000) begin
            n_mismatch++;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic do_reset();
        @(posedge clk);
        nrst <= 1'b0;
        repeat (6) @(posedge clk);
        chk({fpga_reconfig_n, soft_rst, ext_ack, lb_we, lb_re}, 11'h400);
        nrst <= 1'b1;
        @(negedge clk);
        chk({fpga_reconfig_n, soft_rst, ext_ack, lb_we, lb_re}, 11'h400);
    endtask

    // one external cycle; strobe held until acknowledge is seen, dropped on the next edge
    task automatic xfer(input logic [3:0] mid, input logic [11:0] la, input logic wr,
                        input logic [7:0] wd, output logic [7:0] rd);
        int n;
        n = 0;
        seen_we = '0;
        seen_re = '0;
        @(posedge clk);
        ext_addr    <= {mid, la, 16'ha5c3};
        ext_wdata   <= wd;
        ext_we      <= wr;
        read_strobe <= !wr || both;
        @(negedge clk);
        while (ext_ack !== 1'b1 && n < 200) begin
            if ((lb_we | lb_re) !== 4'h0) begin
                seen_addr  = lb_addr;
                seen_wdata = lb_wdata;
            end
            seen_we |= lb_we;
            seen_re |= lb_re;
            n++;
            @(negedge clk);
        end
        rd  = ext_rdata;
        lat = n;
        chk(ext_ack, 1'b1);
        @(posedge clk);
        ext_we      <= 1'b0;
        read_strobe <= 1'b0;
        @(negedge clk);
        chk({ext_ack, lb_we, lb_re}, 9'h0);
    endtask

    task automatic t_ports();
        logic [7:0] rd;
        logic [3:0] mid;
        for (int p = 0; p < 4; p++) begin
            mid = lbc_pkg::LBC_LEAF_MIDS[p*4 +: 4];
            // both strobes on the last port: the write must win
            both = (p == 3);
            xfer(mid, 12'h3a0 + 12'(p), 1'b1, 8'h50 + 8'(p), rd);
            both = 1'b0;
            chk(seen_we, 4'h1 << p);
            chk(seen_re, 4'h0);
            chk({seen_addr, seen_wdata}, {12'h3a0 + 12'(p), 8'h50 + 8'(p)});
            xfer(mid, 12'h3a0 + 12'(p), 1'b0, 8'h00, rd);
            chk({seen_we, seen_re}, 8'h1 << p);
            chk(rd, 8'h50 + 8'(p));
        end
    endtask

    task automatic t_wide();
        logic [7:0]  rd;
        logic [31:0] word;
        logic [3:0]  strobes;
        strobes = '0;
        for (int b = 0; b < 4; b++) begin
            xfer(lbc_pkg::LBC_LEAF_MIDS[11:8], {8'h12, 4'(b)}, 1'b1, 8'(32'hc0de7a41 >> (8 * b)), rd);
        end
        for (int b = 0; b < 4; b++) begin
            xfer(lbc_pkg::LBC_LEAF_MIDS[11:8], {8'h12, 4'(b)}, 1'b0, 8'h00, rd);
            word[b*8 +: 8] = rd;
        end
        chk(word, 32'hc0de7a41);
        for (int b = 0; b < 4; b++) begin
            xfer(lbc_pkg::LBC_MID_SELF, {lbc_pkg::LBC_REG_VERSION, 4'(b)}, 1'b0, 8'h00, rd);
            word[b*8 +: 8] = rd;
            strobes |= seen_we | seen_re;
        end
        chk(word, lbc_pkg::LBC_FW_VERSION);
        // byte select past the version word must not wrap onto a real byte
        xfer(lbc_pkg::LBC_MID_SELF, {lbc_pkg::LBC_REG_VERSION, 4'h6}, 1'b0, 8'h00, rd);
        chk(rd, 8'h00);
        strobes |= seen_we | seen_re;
        xfer(4'h3, 12'h020, 1'b0, 8'h00, rd);
        strobes |= seen_we | seen_re;
        chk({strobes, rd}, 12'h000);
    endtask

    // slow answer with ready noise from unselected ports
    task automatic t_slow();
        logic [7:0] rd;
        int         lat0;
        xfer(lbc_pkg::LBC_LEAF_MIDS[3:0], 12'h3a0, 1'b0, 8'h00, rd);
        lat0 = lat;
        @(posedge clk);
        delay[0] <= 4'h5;
        noise    <= 1'b1;
        xfer(lbc_pkg::LBC_LEAF_MIDS[3:0], 12'h3a0, 1'b0, 8'h00, rd);
        chk(lat - lat0, 5);
        chk({seen_re, rd}, 12'h150);
        @(posedge clk);
        delay[0] <= 4'h0;
        noise    <= 1'b0;
    endtask

    task automatic t_self_ctrl();
        logic [7:0] rd;
        rst_len = 0;
        xfer(lbc_pkg::LBC_MID_SELF, {lbc_pkg::LBC_REG_SOFT_RST, 4'h0}, 1'b1, 8'h01, rd);
        repeat (20) @(negedge clk);
        chk({rst_len[7:0], fpga_reconfig_n}, {8'd8, 1'b1});
        xfer(lbc_pkg::LBC_MID_SELF, {lbc_pkg::LBC_REG_RECONFIG, 4'h0}, 1'b1, 8'h01, rd);
        repeat (10) @(negedge clk);
        chk(fpga_reconfig_n, 1'b0);
        do_reset();
        xfer(lbc_pkg::LBC_LEAF_MIDS[7:4], 12'h3a1, 1'b0, 8'h00, rd);
        chk({seen_re, rd}, 12'h251);
    endtask

    initial begin
        nrst        = 1'b0;
        ext_addr    = '0;
        ext_wdata   = '0;
        ext_we      = 1'b0;
        read_strobe = 1'b0;
        both        = 1'b0;
        delay       = '0;
        noise       = 1'b0;
        n_mismatch  = 0;
        check_count = 0;
        cycles      = 0;
        rst_len     = 0;
        do_reset();
        t_ports();
        t_wide();
        t_slow();
        t_self_ctrl();
        summarize();
    end
endmodule
